// ===== hw/iptc_core.sv
/*
  Interrupt source selection and priority, plus the timer status and
  control register with its counter, compare and capture registers.
  Assumes one 10 MHz clock serving as the E clock, an 8-bit register
  port with read data one cycle after the read strobe, and a CPU core
  that pulses svc_ack once the stacking sequence is done.
*/
`timescale 1ns/1ns
module iptc_core (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic             reg_hit,
  input  wire logic [2:0]  op_mode,
  input  wire logic        nmi_req_n,
  input  wire logic        ext_irq_n,
  input  wire logic        port_three_input_strobe,
  input  wire logic        rx_full_flag,
  input  wire logic        rx_overrun_framing_flag,
  input  wire logic        tx_empty_flag,
  input  wire logic        rx_irq_enable,
  input  wire logic        tx_irq_enable,
  input  wire logic        swi_req,
  input  wire logic        cc_mask_bit,
  input  wire logic        insn_done,
  input  wire logic        svc_ack,
  input  wire logic        compare_out_dir,
  input  wire logic        capture_in_pin,
  output logic             compare_out_pin,
  output logic             compare_out_oe,
  output logic             external_request_line,
  output logic             internal_request_line,
  output logic             svc_start,
  output logic             stack_regs,
  output logic             set_mask,
  output logic      [15:0] vector_addr
);

  typedef enum logic [1:0] {IPTC_IDLE, IPTC_STACK, IPTC_FETCH} iptc_state_t;
  iptc_state_t state_ff;
  logic [4:0]  ctrl_ff;
  logic        tof_ff, ocf_ff, icf_ff;
  logic        tof_arm_ff, ocf_arm_ff, icf_arm_ff;
  logic [15:0] cnt_ff, cmp_ff, cap_ff;
  logic        cmp_inhibit_ff, cap_hold_ff, compare_output_level_latch_ff;
  logic        pin_s1_ff, pin_s2_ff, pin_s3_ff;
  logic        nmi_s1_ff, nmi_s2_ff, nmi_s3_ff, nmi_pend_ff;
  logic        ext_s1_ff, ext_s2_ff, is3_s1_ff, is3_s2_ff;
  logic        ext_ff, int_ff, svc_ff, stack_ff, mask_ff;
  logic [15:0] vec_ff;
  logic [7:0]  rdata_ff;
  logic        hit_ff;

  logic [15:0] base;
  logic        in_area;
  logic [4:0]  ofs;
  logic        wr_hit, rd_hit;
  logic        cap_edge, cmp_match, ovf_now;
  logic        ser_req, tim_req, ext_req, maskable;
  logic [15:0] nxt_vec;
  logic [7:0]  status;

  ////////////////////////////////////////////////////////////////////////
  // Register decode
  // Whole internal area moves to the high range in mode three
  assign base    = (op_mode == iptc_pkg::MODE_REG_HIGH) ?
                   iptc_pkg::REG_BASE_HIGH : iptc_pkg::REG_BASE_LOW;
  assign in_area = (reg_addr[15:5] == base[15:5]);
  assign ofs     = reg_addr[4:0];
  assign wr_hit  = reg_wr && in_area;
  assign rd_hit  = reg_rd && in_area;
  assign status  = {icf_ff, ocf_ff, tof_ff, ctrl_ff};
  ////////////////////////////////////////////////////////////////////////
  // Synchronisers for pins from outside the clock domain
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_ff <= 1'b0;
      pin_s2_ff <= 1'b0;
      pin_s3_ff <= 1'b0;
      nmi_s1_ff <= 1'b1;
      nmi_s2_ff <= 1'b1;
      nmi_s3_ff <= 1'b1;
      ext_s1_ff <= 1'b1;
      ext_s2_ff <= 1'b1;
      is3_s1_ff <= 1'b0;
      is3_s2_ff <= 1'b0;
    end else begin
      pin_s1_ff <= capture_in_pin;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      nmi_s1_ff <= nmi_req_n;
      nmi_s2_ff <= nmi_s1_ff;
      nmi_s3_ff <= nmi_s2_ff;
      ext_s1_ff <= ext_irq_n;
      ext_s2_ff <= ext_s1_ff;
      is3_s1_ff <= port_three_input_strobe;
      is3_s2_ff <= is3_s1_ff;
    end
  end

  // Edge select: zero takes falling, one takes rising
  assign cap_edge = ctrl_ff[iptc_pkg::BIT_CAPTURE_EDGE_SELECT] ?
                    (pin_s2_ff && !pin_s3_ff) :
                    (!pin_s2_ff && pin_s3_ff);
  ////////////////////////////////////////////////////////////////////////
  // Timer datapath
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      cnt_ff <= iptc_pkg::CNT_RESET;
    else if (wr_hit && ofs == iptc_pkg::OFS_CNT_HI)
      cnt_ff <= iptc_pkg::CNT_PRESET;
    else
      cnt_ff <= cnt_ff + 16'h0001;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_ff         <= iptc_pkg::CMP_RESET;
      cmp_inhibit_ff <= 1'b0;
    end else begin
      // One quiet cycle after a high-byte write avoids a false match
      cmp_inhibit_ff <= wr_hit && ofs == iptc_pkg::OFS_CMP_HI;
      if (wr_hit && ofs == iptc_pkg::OFS_CMP_HI)
        cmp_ff[15:8] <= reg_wdata;
      if (wr_hit && ofs == iptc_pkg::OFS_CMP_LO)
        cmp_ff[7:0] <= reg_wdata;
    end
  end

  assign cmp_match = (cmp_ff == cnt_ff) && !cmp_inhibit_ff;
  assign ovf_now   = (cnt_ff == 16'hffff);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_ff      <= iptc_pkg::CAP_RESET;
      cap_hold_ff <= 1'b0;
    end else begin
      // Hold the pair stable between high and low byte reads
      if (rd_hit && ofs == iptc_pkg::OFS_CAP_HI)
        cap_hold_ff <= 1'b1;
      else if (rd_hit && ofs == iptc_pkg::OFS_CAP_LO)
        cap_hold_ff <= 1'b0;
      if (cap_edge && !cap_hold_ff)
        cap_ff <= cnt_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      ctrl_ff <= iptc_pkg::CTRL_RESET;
    else if (wr_hit && ofs == iptc_pkg::OFS_TIMER_CTRL_STATUS)
      ctrl_ff <= reg_wdata[4:0];
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      compare_output_level_latch_ff <= 1'b0;
    else if (cmp_match)
      compare_output_level_latch_ff <= ctrl_ff[iptc_pkg::BIT_COMPARE_OUTPUT_LEVEL];
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      compare_out_pin <= 1'b0;
      compare_out_oe  <= 1'b0;
    end else begin
      compare_out_pin <= compare_output_level_latch_ff;
      compare_out_oe  <= compare_out_dir;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flags: a set in the same cycle as the clearing access wins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tof_ff     <= 1'b0;
      ocf_ff     <= 1'b0;
      icf_ff     <= 1'b0;
      tof_arm_ff <= 1'b0;
      ocf_arm_ff <= 1'b0;
      icf_arm_ff <= 1'b0;
    end else begin
      if (rd_hit && ofs == iptc_pkg::OFS_TIMER_CTRL_STATUS) begin
        tof_arm_ff <= tof_ff;
        ocf_arm_ff <= ocf_ff;
        icf_arm_ff <= icf_ff;
      end
      if (ovf_now)
        tof_ff <= 1'b1;
      else if (tof_arm_ff && rd_hit && ofs == iptc_pkg::OFS_CNT_HI) begin
        tof_ff     <= 1'b0;
        tof_arm_ff <= 1'b0;
      end
      if (cmp_match)
        ocf_ff <= 1'b1;
      else if (ocf_arm_ff && wr_hit &&
               (ofs == iptc_pkg::OFS_CMP_HI ||
                ofs == iptc_pkg::OFS_CMP_LO)) begin
        ocf_ff     <= 1'b0;
        ocf_arm_ff <= 1'b0;
      end
      if (cap_edge)
        icf_ff <= 1'b1;
      else if (icf_arm_ff && rd_hit && ofs == iptc_pkg::OFS_CAP_HI) begin
        icf_ff     <= 1'b0;
        icf_arm_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read port
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
      hit_ff   <= 1'b0;
    end else begin
      hit_ff <= rd_hit;
      if (!rd_hit)
        rdata_ff <= 8'h00;
      else
        unique case (ofs)
          iptc_pkg::OFS_TIMER_CTRL_STATUS:   rdata_ff <= status;
          iptc_pkg::OFS_CNT_HI: rdata_ff <= cnt_ff[15:8];
          iptc_pkg::OFS_CNT_LO: rdata_ff <= cnt_ff[7:0];
          iptc_pkg::OFS_CMP_HI: rdata_ff <= cmp_ff[15:8];
          iptc_pkg::OFS_CMP_LO: rdata_ff <= cmp_ff[7:0];
          iptc_pkg::OFS_CAP_HI: rdata_ff <= cap_ff[15:8];
          iptc_pkg::OFS_CAP_LO: rdata_ff <= cap_ff[7:0];
          iptc_pkg::OFS_MIR_HI: rdata_ff <= cnt_ff[15:8];
          iptc_pkg::OFS_MIR_LO: rdata_ff <= cnt_ff[7:0];
          default:              rdata_ff <= 8'h00;
        endcase
    end
  end

  assign reg_rdata = rdata_ff;
  assign reg_hit   = hit_ff;
  ////////////////////////////////////////////////////////////////////////
  // Request lines and priority
  // Three serial conditions share one request and one slot
  assign ser_req = ((rx_full_flag || rx_overrun_framing_flag) &&
                    rx_irq_enable) ||
                   (tx_empty_flag && tx_irq_enable);
  assign tim_req = (icf_ff && ctrl_ff[iptc_pkg::BIT_CAPTURE_IRQ_ENABLE]) ||
                   (ocf_ff && ctrl_ff[iptc_pkg::BIT_COMPARE_IRQ_ENABLE]) ||
                   (tof_ff && ctrl_ff[iptc_pkg::BIT_OVERFLOW_IRQ_ENABLE]);
  assign ext_req = !ext_s2_ff || is3_s2_ff;
  assign maskable = !cc_mask_bit && (ext_ff || int_ff);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_ff <= 1'b0;
      int_ff <= 1'b0;
    end else begin
      ext_ff <= ext_req;
      int_ff <= tim_req || ser_req;
    end
  end

  assign external_request_line = ext_ff;
  assign internal_request_line = int_ff;
  // Non-maskable request is latched on its falling edge until served
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      nmi_pend_ff <= 1'b0;
    else if (!nmi_s2_ff && nmi_s3_ff)
      nmi_pend_ff <= 1'b1;
    else if (state_ff == IPTC_FETCH && svc_ack && vec_ff[3:0] == 4'hc)
      nmi_pend_ff <= 1'b0;
  end

  always_comb begin
    if (nmi_pend_ff)
      nxt_vec = iptc_pkg::VEC_NMI;
    else if (swi_req)
      nxt_vec = iptc_pkg::VEC_SWI;
    else if (ext_ff)
      nxt_vec = iptc_pkg::VEC_EXT;
    else if (icf_ff && ctrl_ff[iptc_pkg::BIT_CAPTURE_IRQ_ENABLE])
      nxt_vec = iptc_pkg::VEC_CAP;
    else if (ocf_ff && ctrl_ff[iptc_pkg::BIT_COMPARE_IRQ_ENABLE])
      nxt_vec = iptc_pkg::VEC_CMP;
    else if (tof_ff && ctrl_ff[iptc_pkg::BIT_OVERFLOW_IRQ_ENABLE])
      nxt_vec = iptc_pkg::VEC_OVF;
    else
      nxt_vec = iptc_pkg::VEC_SER;
    // Mode zero fetches from the external relocated range
    if (op_mode == iptc_pkg::MODE_EXT_VEC)
      nxt_vec = nxt_vec & iptc_pkg::VEC_RELOC_AND;
  end

  ////////////////////////////////////////////////////////////////////////
  // Service sequence: stack, set mask, hand vector to the core
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= IPTC_IDLE;
      svc_ff   <= 1'b0;
      stack_ff <= 1'b0;
      mask_ff  <= 1'b0;
      vec_ff   <= iptc_pkg::VEC_RESET;
    end else begin
      svc_ff  <= 1'b0;
      mask_ff <= 1'b0;
      unique case (state_ff)
        IPTC_IDLE: begin
          if (insn_done && (nmi_pend_ff || swi_req || maskable)) begin
            state_ff <= IPTC_STACK;
            svc_ff   <= 1'b1;
            stack_ff <= 1'b1;
          end
        end
        IPTC_STACK: begin
          if (svc_ack) begin
            stack_ff <= 1'b0;
            mask_ff  <= 1'b1;
            vec_ff   <= nxt_vec;
            state_ff <= IPTC_FETCH;
          end
        end
        IPTC_FETCH: begin
          if (svc_ack)
            state_ff <= IPTC_IDLE;
        end
      endcase
    end
  end

  assign svc_start   = svc_ff;
  assign stack_regs  = stack_ff;
  assign set_mask    = mask_ff;
  assign vector_addr = vec_ff;
  ////////////////////////////////////////////////////////////////////////
  // Checks
  tof_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ovf_now |=> tof_ff) else $error("overflow flag not set");
  ocf_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cmp_match |=> ocf_ff) else $error("compare flag not set");
  icf_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cap_edge |=> icf_ff) else $error("capture flag not set");
  cnt_step_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(rst_n) && !$past(wr_hit) |-> cnt_ff == $past(cnt_ff) + 16'h0001)
    else $error("counter did not advance");
  mirror_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tof_ff && !tof_arm_ff |=> tof_ff)
    else $error("overflow flag cleared unarmed");
  int_line_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ctrl_ff[4:2] == 3'b000 && !ser_req |=> !int_ff)
    else $error("internal line without enable");
  compare_output_level_copy_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cmp_match |=> ##1 compare_out_pin == $past(ctrl_ff[0], 2))
    else $error("output level not copied");
  ext_first_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_ff == IPTC_STACK && svc_ack && ext_ff && !nmi_pend_ff && !swi_req
    |=> vec_ff[3:0] == 4'h8) else $error("external not first");
  mask_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_ff == IPTC_STACK && svc_ack |=> set_mask)
    else $error("mask not set on service");
  ctrl_wr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_hit && ofs == iptc_pkg::OFS_TIMER_CTRL_STATUS |=> ctrl_ff == $past(reg_wdata[4:0]))
    else $error("control write lost");

  svc_c:  cover property (@(posedge ref_clk) disable iff (!rst_n)
    svc_ff ##[1:20] mask_ff);
  clr_c:  cover property (@(posedge ref_clk) disable iff (!rst_n)
    tof_ff ##1 !tof_ff);
  cap_c:  cover property (@(posedge ref_clk) disable iff (!rst_n) cap_edge);
  nmi_c:  cover property (@(posedge ref_clk) disable iff (!rst_n)
    nmi_pend_ff && cc_mask_bit && svc_ff);

endmodule

// ===== hw/iptc_pkg.sv
/*
  Constants for the interrupt priority and timer status block: register
  offsets, field positions, reset values and vector slot addresses.
  Assumes an 8-bit register port with byte offsets in the low 5 bits.
*/
package iptc_pkg;

  localparam logic [4:0] OFS_TIMER_CTRL_STATUS      = 5'h08;
  localparam logic [4:0] OFS_CNT_HI    = 5'h09;
  localparam logic [4:0] OFS_CNT_LO    = 5'h0a;
  localparam logic [4:0] OFS_CMP_HI    = 5'h0b;
  localparam logic [4:0] OFS_CMP_LO    = 5'h0c;
  localparam logic [4:0] OFS_CAP_HI    = 5'h0d;
  localparam logic [4:0] OFS_CAP_LO    = 5'h0e;
  localparam logic [4:0] OFS_MIR_HI    = 5'h15;
  localparam logic [4:0] OFS_MIR_LO    = 5'h16;

  localparam logic [15:0] REG_BASE_LOW  = 16'h0000;
  localparam logic [15:0] REG_BASE_HIGH = 16'hc000;
  localparam logic [2:0]  MODE_EXT_VEC  = 3'h0;
  localparam logic [2:0]  MODE_REG_HIGH = 3'h3;

  localparam int BIT_COMPARE_OUTPUT_LEVEL = 0;
  localparam int BIT_CAPTURE_EDGE_SELECT = 1;
  localparam int BIT_OVERFLOW_IRQ_ENABLE = 2;
  localparam int BIT_COMPARE_IRQ_ENABLE = 3;
  localparam int BIT_CAPTURE_IRQ_ENABLE = 4;
  localparam int BIT_TOF  = 5;
  localparam int BIT_OCF  = 6;
  localparam int BIT_ICF  = 7;

  localparam logic [4:0]  CTRL_RESET    = 5'h00;
  localparam logic [15:0] CNT_RESET     = 16'h0000;
  localparam logic [15:0] CNT_PRESET    = 16'hfff8;
  localparam logic [15:0] CMP_RESET     = 16'hffff;
  localparam logic [15:0] CAP_RESET     = 16'h0000;

  localparam logic [15:0] VEC_RESET     = 16'hfffe;
  localparam logic [15:0] VEC_NMI       = 16'hfffc;
  localparam logic [15:0] VEC_SWI       = 16'hfffa;
  localparam logic [15:0] VEC_EXT       = 16'hfff8;
  localparam logic [15:0] VEC_CAP       = 16'hfff6;
  localparam logic [15:0] VEC_CMP       = 16'hfff4;
  localparam logic [15:0] VEC_OVF       = 16'hfff2;
  localparam logic [15:0] VEC_SER       = 16'hfff0;
  localparam logic [15:0] VEC_RELOC_AND = 16'hbfff;

endpackage

// ===== sim/iptc_cpu_model.sv
/*
  Behavioural CPU core on the far side of the interrupt block: marks
  instruction boundaries, acknowledges stacking and vector fetch, and
  keeps the I mask. Assumes the stack_regs / set_mask hand-over timing.
*/
`timescale 1ns/1ns
module iptc_cpu_model (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        stack_regs,
  input  wire logic        set_mask,
  input  wire logic [15:0] vector_addr,
  input  wire logic        slow,
  input  wire logic        unmask,
  output logic             insn_done,
  output logic             svc_ack,
  output logic             cc_mask_bit,
  output logic      [15:0] last_vec,
  output int               vec_cnt
);
  logic [1:0] ph_ff;
  logic [1:0] st_ff;
  logic [2:0] wait_ff;
  ////////////////////////////////////////
  // Boundary every fourth cycle, none while a service is running
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_ff     <= 2'h0;
      insn_done <= 1'b0;
    end else begin
      ph_ff     <= ph_ff + 2'h1;
      insn_done <= (ph_ff == 2'h3) && (st_ff == 2'h0);
    end
  end
  // Mask starts set, as a core does out of reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff       <= 2'h0;
      wait_ff     <= 3'h0;
      svc_ack     <= 1'b0;
      cc_mask_bit <= 1'b1;
      last_vec    <= 16'h0000;
      vec_cnt     <= 0;
    end else begin
      svc_ack <= 1'b0;
      if (unmask) begin
        cc_mask_bit <= 1'b0;
      end
      case (st_ff)
        2'h0: begin
          wait_ff <= slow ? 3'h5 : 3'h0;
          if (stack_regs) begin
            st_ff <= 2'h1;
          end
        end
        2'h1: begin
          if (wait_ff != 3'h0) begin
            wait_ff <= wait_ff - 3'h1;
          end else begin
            svc_ack <= 1'b1;
            st_ff   <= 2'h2;
          end
        end
        2'h2: begin
          if (set_mask) begin
            cc_mask_bit <= 1'b1;
            last_vec    <= vector_addr;
            vec_cnt     <= vec_cnt + 1;
            svc_ack     <= 1'b1;
            st_ff       <= 2'h3;
          end
        end
        default: st_ff <= 2'h0;
      endcase
    end
  end
endmodule

// ===== sim/irq_priority_timer_status_tb.sv
/*
  Self-checking bench for the interrupt priority and timer status block.
  Assumes iptc_pkg, iptc_core and the CPU model iptc_cpu_model.
*/
`timescale 1ns/1ns
module irq_priority_timer_status_tb;
  logic        ref_clk, rst_n, reg_wr, reg_rd, reg_hit, nmi_req_n, ext_irq_n;
  logic        port_three_input_strobe, rx_full_flag, rx_overrun_framing_flag;
  logic        tx_empty_flag, rx_irq_enable, tx_irq_enable, swi_req;
  logic        cc_mask_bit, insn_done, svc_ack, compare_out_dir, set_mask;
  logic        capture_in_pin, compare_out_pin, compare_out_oe, svc_start;
  logic        external_request_line, internal_request_line, stack_regs;
  logic        slow, unmask, hit;
  logic [2:0]  op_mode;
  logic [7:0]  reg_wdata, reg_rdata, d, c0;
  logic [15:0] reg_addr, vector_addr, last_vec, tgt;
  int          vec_cnt, error_cnt, num_checks, g, svc_seen;

  iptc_core uut (
    .ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .reg_hit, .op_mode, .nmi_req_n, .ext_irq_n, .port_three_input_strobe,
    .rx_full_flag, .rx_overrun_framing_flag, .tx_empty_flag, .rx_irq_enable,
    .tx_irq_enable, .swi_req, .cc_mask_bit, .insn_done, .svc_ack,
    .compare_out_dir, .capture_in_pin, .compare_out_pin, .compare_out_oe,
    .external_request_line, .internal_request_line, .svc_start,
    .stack_regs, .set_mask, .vector_addr
  );
  iptc_cpu_model cpu (
    .ref_clk, .rst_n, .stack_regs, .set_mask, .vector_addr, .slow, .unmask,
    .insn_done, .svc_ack, .cc_mask_bit, .last_vec, .vec_cnt
  );
  ////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // One service start per vector that the core fetches
  always @(posedge ref_clk) begin
    if (svc_start) begin
      svc_seen <= svc_seen + 1;
    end
  end
  function automatic logic [15:0] ra(input logic [4:0] o);
    return {11'h000, o};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    v   = reg_rdata;
    hit = reg_hit;
  endtask
  task automatic expect_vec(input logic [15:0] exp, input logic open);
    int n0;
    n0 = vec_cnt;
    if (open) begin
      @(posedge ref_clk);
      slow   <= 1'($urandom);
      unmask <= 1'b1;
      @(posedge ref_clk);
      unmask <= 1'b0;
    end
    repeat (80) begin
      if (vec_cnt == n0) begin
        @(posedge ref_clk);
      end
    end
    check(16'(vec_cnt - n0), 16'h0001);
    check(last_vec, exp);
  endtask
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #(100 * 20000);
    error_cnt++;
    report_and_stop();
  end
  ////////////////////////////////////////
  initial begin
    {rst_n, reg_wr, reg_rd, port_three_input_strobe, rx_full_flag} = '0;
    {rx_overrun_framing_flag, tx_empty_flag, rx_irq_enable} = '0;
    {tx_irq_enable, swi_req, compare_out_dir, capture_in_pin} = '0;
    {slow, unmask, reg_addr, reg_wdata, error_cnt, num_checks, svc_seen} = '0;
    {nmi_req_n, ext_irq_n} = 2'h3;
    op_mode = 3'h2;
    void'($urandom(32'hb81c));
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(ra(iptc_pkg::OFS_TIMER_CTRL_STATUS), d);
    check(16'(d), 16'h0000);
    check(16'(compare_out_pin), 16'h0000);
    rd(ra(iptc_pkg::OFS_CMP_LO), d);
    check(16'(d), 16'h00ff);
    for (int i = 0; i < 3; i++) begin
      g = $urandom_range(12, 1);
      rd(ra(iptc_pkg::OFS_MIR_LO), c0);
      repeat (g) @(posedge ref_clk);
      rd(ra(iptc_pkg::OFS_MIR_LO), d);
      check({8'h00, d - c0}, 16'(g + 2));
    end
    for (int i = 0; i < 4; i++) begin
      c0 = 8'($urandom);
      wr(ra(iptc_pkg::OFS_TIMER_CTRL_STATUS), c0);
      rd(ra(iptc_pkg::OFS_TIMER_CTRL_STATUS), d);
      check(16'(d), 16'(c0 & 8'h1f));
    end
    wr(ra(iptc_pkg::OFS_TIMER_CTRL_STATUS), 8'h00);
    rx_full_flag <= 1'b1;
    repeat (5) @(posedge ref_clk);
    check(16'(internal_request_line), 16'h0000);
    {rx_irq_enable, tx_irq_enable} <= 2'h3;
    ext_irq_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    check(16'({external_request_line, internal_request_line}), 16'h0003);
    check(16'(vec_cnt), 16'h0000);
    expect_vec(iptc_pkg::VEC_EXT, 1'b1);
    ext_irq_n <= 1'b1;
    port_three_input_strobe <= 1'b1;
    repeat (5) @(posedge ref_clk);
    expect_vec(iptc_pkg::VEC_EXT, 1'b1);
    port_three_input_strobe <= 1'b0;
    // Each serial condition alone must reach the shared slot
    for (int i = 0; i < 3; i++) begin
      {tx_empty_flag, rx_overrun_framing_flag, rx_full_flag} <= 3'h1 << i;
      repeat (5) @(posedge ref_clk);
      expect_vec(iptc_pkg::VEC_SER, 1'b1);
    end
    {tx_empty_flag, rx_overrun_framing_flag, rx_full_flag} <= 3'h0;
    wr(ra(iptc_pkg::OFS_CNT_HI), 8'h00);
    repeat (12) @(posedge ref_clk);
    rd(ra(iptc_pkg::OFS_TIMER_CTRL_STATUS), d);
    check(16'(d[7:5]), 16'h0003);
    check(16'(internal_request_line), 16'h0000);
    wr(ra(iptc_pkg::OFS_TIMER_CTRL_STATUS), 8'h04);
    repeat (3) @(posedge ref_clk);
    check(16'(internal_request_line), 16'h0001);
    expect_vec(iptc_pkg::VEC_OVF, 1'b1);
    rd(ra(iptc_pkg::OFS_TIMER_CTRL_STATUS), d);
    rd(ra(iptc_pkg::OFS_MIR_HI), d);
    rd(ra(iptc_pkg::OFS_TIMER_CTRL_STATUS), d);
    check(16'(d[7:5]), 16'h0003);
    rd(ra(iptc_pkg::OFS_CNT_HI), d);
    rd(ra(iptc_pkg::OFS_TIMER_CTRL_STATUS), d);
    check(16'(d[7:5]), 16'h0002);
    check(16'(internal_request_line), 16'h0000);
    rd(ra(iptc_pkg::OFS_MIR_HI), d);
    rd(ra(iptc_pkg::OFS_MIR_LO), c0);
    // A carry between the two byte reads bumps the high byte
    tgt = {d, c0} + 16'h0040 + ((c0 < 8'h02) ? 16'h0100 : 16'h0000);
    rd(ra(iptc_pkg::OFS_TIMER_CTRL_STATUS), d);
    wr(ra(iptc_pkg::OFS_CMP_HI), tgt[15:8]);
    wr(ra(iptc_pkg::OFS_CMP_LO), tgt[7:0]);
    compare_out_dir <= 1'b1;
    wr(ra(iptc_pkg::OFS_TIMER_CTRL_STATUS), 8'h09);
    rd(ra(iptc_pkg::OFS_TIMER_CTRL_STATUS), d);
    check(16'(d), 16'h0009);
    repeat (70) @(posedge ref_clk);
    check(16'({compare_out_oe, compare_out_pin}), 16'h0003);
    expect_vec(iptc_pkg::VEC_CMP, 1'b1);
    rd(ra(iptc_pkg::OFS_TIMER_CTRL_STATUS), d);
    check(16'(d[7:5]), 16'h0002);
    wr(ra(iptc_pkg::OFS_CMP_LO), tgt[7:0]);
    rd(ra(iptc_pkg::OFS_TIMER_CTRL_STATUS), d);
    check(16'(d[7:5]), 16'h0000);
    wr(ra(iptc_pkg::OFS_TIMER_CTRL_STATUS), 8'h10);
    @(posedge ref_clk);
    capture_in_pin <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd(ra(iptc_pkg::OFS_TIMER_CTRL_STATUS), d);
    check(16'(d[7:5]), 16'h0000);
    rd(ra(iptc_pkg::OFS_MIR_LO), c0);
    @(posedge ref_clk);
    capture_in_pin <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rd(ra(iptc_pkg::OFS_TIMER_CTRL_STATUS), d);
    check(16'(d[7:5]), 16'h0004);
    rd(ra(iptc_pkg::OFS_CAP_HI), d);
    rd(ra(iptc_pkg::OFS_CAP_LO), d);
    check(16'(8'(d - c0) < 8'h0a), 16'h0001);
    rd(ra(iptc_pkg::OFS_TIMER_CTRL_STATUS), d);
    check(16'(d[7:5]), 16'h0000);
    wr(ra(iptc_pkg::OFS_TIMER_CTRL_STATUS), 8'h12);
    @(posedge ref_clk);
    capture_in_pin <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd(ra(iptc_pkg::OFS_TIMER_CTRL_STATUS), d);
    check(16'(d[7:5]), 16'h0004);
    expect_vec(iptc_pkg::VEC_CAP, 1'b1);
    rd(ra(iptc_pkg::OFS_CAP_HI), d);
    rd(ra(iptc_pkg::OFS_CAP_LO), d);
    // Both of these are taken with the mask still set
    @(posedge ref_clk);
    nmi_req_n <= 1'b0;
    expect_vec(iptc_pkg::VEC_NMI, 1'b0);
    nmi_req_n <= 1'b1;
    op_mode   <= 3'h0;
    swi_req   <= 1'b1;
    expect_vec(iptc_pkg::VEC_SWI & iptc_pkg::VEC_RELOC_AND, 1'b0);
    swi_req <= 1'b0;
    op_mode <= 3'h3;
    rd(iptc_pkg::REG_BASE_HIGH | 16'h0008, d);
    check(16'({hit, d}), 16'h0112);
    rd(ra(iptc_pkg::OFS_TIMER_CTRL_STATUS), d);
    check(16'({hit, d}), 16'h0000);
    check(16'(svc_seen), 16'(vec_cnt));
    report_and_stop();
  end
endmodule
